/* rtl/oos_pkg.sv */
// constants for the operation / overload status bank
// assumes a single 100 MHz clock domain; no timing counts are needed
package oos_pkg;
    // ------------------------------------------------------------
    // register selects on the command port
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_OPER_COND = 2'h0;
    localparam logic [1:0] SEL_OPER_EVENT = 2'h1;
    localparam logic [1:0] SEL_OVL_MASK = 2'h2;
    localparam logic [1:0] SEL_OVL_EVENT = 2'h3;
    // ------------------------------------------------------------
    // operation status field positions
    // ------------------------------------------------------------
    localparam int OPER_RUN_BIT = 3;
    localparam int OPER_ARMED_BIT = 5;
    localparam int OPER_OVL_BIT = 11;
    localparam int OPER_HWE_BIT = 12;
    localparam logic [15:0] OPER_USED = 16'h1828;
    // ------------------------------------------------------------
    // overload event field positions
    // ------------------------------------------------------------
    localparam int OVL_CH_LSB = 0;
    localparam int FLT_CH_LSB = 6;
    localparam int NUM_SRC = 5;
    localparam logic [15:0] OVL_USED = 16'h07DF;
    localparam logic [15:0] OVL_MASK_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam int STB_OPER_BIT = 7;
    // acquisition modes
    typedef enum logic [1:0] {
        OOS_ACQ_STOP,
        OOS_ACQ_SINGLE,
        OOS_ACQ_RUN
    } oos_acq_e;
endpackage

/* rtl/oos_status_bank.sv */
// operation condition/event and overload event/mask registers
// assumes sources come from logic on ref_clk, except overload
// and fault detectors, which are asynchronous pins and get synchronised
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: condition bit 12 high when a hardware event has occurred.
// R2: terminated-input overload sets bit 11 of condition and event.
// R3: bit 5 follows the trigger-armed latch.
// R4: condition bit 3 high while acquisition runs, low when stopped.
// R5: event bit 3 set on stop to single or run transition.
// R6: overload mask is stored and read back unchanged.
// R7: enabled overload event sets operation bit 11.
// R8: overload flags on bits 0-3 for channels, bit 4 external trigger.
// R9: fault flags on bits 6-9 for channels, bit 10 external trigger.
// R10: each mask bit gates the event bit at the same position.
// R11: overvoltage on low-impedance input commands high impedance.
// R12: a one in an overload event bit means that overload occurred.
// R13: operation status reads return the whole register value.
// R14: enabled operation bits summarise into status byte bit 7.
// R15: unused bits read zero and ignore writes.
// R16: event bits stick until cleared or reset; condition follows.
module oos_status_bank (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // command port
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic cmd_clr,
    input wire logic [1:0] cmd_sel,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] operation_enable_mask,
    output logic [15:0] cmd_rdata_q,
    output logic cmd_rvalid_q,
    // instrument state
    input wire logic hardware_event_summary,
    input wire logic trigger_armed_latch,
    input wire oos_pkg::oos_acq_e acq_state,
    // input protection pins, ch1..ch4 then external trigger
    input wire logic [4:0] ovl_pin,
    input wire logic [4:0] fault_pin,
    input wire logic [4:0] low_z_sel,
    output logic [4:0] force_high_z_q,
    // summary
    output logic stb_oper_summary_q
);
    // ------------------------------------------------------------
    // synchronisers and overload capture
    // ------------------------------------------------------------
    logic [4:0] ovl_s1_q, ovl_s2_q, flt_s1_q, flt_s2_q;
    logic [15:0] ovl_src;
    logic [15:0] ovl_event_q;
    logic [15:0] overload_enable_bits_q;
    logic overload_summary;

    // two stages per pin; only the second stage feeds any logic, so a
    // pin edge near the clock cannot split between consumers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ovl_s1_q <= 5'h00;
            ovl_s2_q <= 5'h00;
        end else begin
            ovl_s1_q <= ovl_pin;
            ovl_s2_q <= ovl_s1_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flt_s1_q <= 5'h00;
            flt_s2_q <= 5'h00;
        end else begin
            flt_s1_q <= fault_pin;
            flt_s2_q <= flt_s1_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < oos_pkg::NUM_SRC; gi++) begin : g_src
            assign ovl_src[oos_pkg::OVL_CH_LSB + gi] = ovl_s2_q[gi]; // [R8]
            assign ovl_src[oos_pkg::FLT_CH_LSB + gi] = flt_s2_q[gi]; // [R9]
        end
    endgenerate
    assign ovl_src[5] = 1'b0;
    assign ovl_src[15:11] = 5'h00;

    // set wins over clear so a fresh overload is never lost
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ovl_event_q <= oos_pkg::STATUS_RESET;
        end else if (cmd_clr && cmd_sel == oos_pkg::SEL_OVL_EVENT) begin
            ovl_event_q <= ovl_src & oos_pkg::OVL_USED; // [R16]
        end else begin
            ovl_event_q <= (ovl_event_q | ovl_src)
                & oos_pkg::OVL_USED; // [R12]
        end
    end

    // ------------------------------------------------------------
    // overload enable mask
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            overload_enable_bits_q <= oos_pkg::OVL_MASK_RESET;
        end else if (cmd_wr && cmd_sel == oos_pkg::SEL_OVL_MASK) begin
            // unused positions cannot be stored [R15]
            overload_enable_bits_q <= cmd_wdata & oos_pkg::OVL_USED; // [R6]
        end
    end

    // enabled overloads only; a masked source still shows in the
    // overload event register but reaches the operation bit only while its mask bit is set
    assign overload_summary =
        |(ovl_event_q & overload_enable_bits_q); // [R10] [R7]

    // ------------------------------------------------------------
    // automatic switch to high impedance
    // ------------------------------------------------------------
    // held until software deselects low impedance, so a brief pulse
    // still protects the input
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            force_high_z_q <= 5'h00;
        end else begin
            force_high_z_q <= (force_high_z_q | (ovl_s2_q & low_z_sel))
                & low_z_sel; // [R11]
        end
    end

    // ------------------------------------------------------------
    // operation condition and event
    // ------------------------------------------------------------
    logic [15:0] oper_cond;
    logic [15:0] oper_event_q;
    logic [15:0] oper_set;
    oos_pkg::oos_acq_e acq_prev_q;
    logic run_start;

    always_comb begin
        oper_cond = 16'h0000;
        oper_cond[oos_pkg::OPER_HWE_BIT] = hardware_event_summary; // [R1]
        oper_cond[oos_pkg::OPER_OVL_BIT] = overload_summary; // [R2]
        oper_cond[oos_pkg::OPER_ARMED_BIT] = trigger_armed_latch; // [R3]
        oper_cond[oos_pkg::OPER_RUN_BIT] =
            (acq_state != oos_pkg::OOS_ACQ_STOP); // [R4]
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            acq_prev_q <= oos_pkg::OOS_ACQ_STOP;
        end else begin
            acq_prev_q <= acq_state;
        end
    end

    // only the stop to non-stop edge counts; single to run does not
    // set the event bit again
    assign run_start = (acq_prev_q == oos_pkg::OOS_ACQ_STOP) &&
        (acq_state != oos_pkg::OOS_ACQ_STOP); // [R5]

    always_comb begin
        oper_set = oper_cond;
        oper_set[oos_pkg::OPER_RUN_BIT] = run_start;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            oper_event_q <= oos_pkg::STATUS_RESET;
        end else if (cmd_clr && cmd_sel == oos_pkg::SEL_OPER_EVENT) begin
            oper_event_q <= oper_set & oos_pkg::OPER_USED; // [R16]
        end else begin
            oper_event_q <= (oper_event_q | oper_set) & oos_pkg::OPER_USED;
        end
    end

    // ------------------------------------------------------------
    // read port and status byte summary
    // ------------------------------------------------------------
    logic [15:0] rd_word;

    // condition bits are taken at the read edge, so a level that
    // changes in that cycle reads as its value just before the edge
    always_comb begin
        rd_word = 16'h0000;
        case (cmd_sel)
            oos_pkg::SEL_OPER_COND: rd_word = oper_cond; // [R13]
            oos_pkg::SEL_OPER_EVENT: rd_word = oper_event_q; // [R13]
            oos_pkg::SEL_OVL_MASK: rd_word = overload_enable_bits_q; // [R6]
            oos_pkg::SEL_OVL_EVENT: rd_word = ovl_event_q; // [R12]
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmd_rvalid_q <= 1'b0;
        end else begin
            cmd_rvalid_q <= cmd_rd;
        end
    end

    // data holds between reads so a slow reader can take it late
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmd_rdata_q <= 16'h0000;
        end else if (cmd_rd) begin
            cmd_rdata_q <= rd_word;
        end
    end

    // gated by the operation mask only; unused positions never count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stb_oper_summary_q <= 1'b0;
        end else begin
            stb_oper_summary_q <= |(oper_event_q & operation_enable_mask
                & oos_pkg::OPER_USED); // [R14]
        end
    end
endmodule
`default_nettype wire

/* bench/oos_status_bank_asserts.sv */
// port-level checks for the operation / overload status bank
// bound to oos_status_bank from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module oos_status_bank_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // command port
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic cmd_clr,
    input wire logic [1:0] cmd_sel,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] operation_enable_mask,
    input wire logic [15:0] cmd_rdata_q,
    input wire logic cmd_rvalid_q,
    // instrument state
    input wire logic hardware_event_summary,
    input wire logic trigger_armed_latch,
    input wire oos_pkg::oos_acq_e acq_state,
    // protection pins and summary
    input wire logic [4:0] ovl_pin,
    input wire logic [4:0] fault_pin,
    input wire logic [4:0] low_z_sel,
    input wire logic [4:0] force_high_z_q,
    input wire logic stb_oper_summary_q
);
// ------------------------------------------------------------
// assertions
// ------------------------------------------------------------
default clocking cb @(posedge ref_clk); endclocking
default disable iff (sys_rst);
rd_answer_a: assert property (cmd_rd |=> cmd_rvalid_q)
    else $error("read not answered");
oper_unused_a: assert property (cmd_rvalid_q && !$past(cmd_sel[1]) |->
    (cmd_rdata_q & ~oos_pkg::OPER_USED) == 16'h0000)
    else $error("operation unused bit set");
ovl_unused_a: assert property (cmd_rvalid_q && $past(cmd_sel[1]) |->
    (cmd_rdata_q & ~oos_pkg::OVL_USED) == 16'h0000)
    else $error("overload unused bit set");
mask_back_a: assert property (cmd_wr && cmd_sel == 2'h2 ##1 cmd_rd &&
    cmd_sel == 2'h2 |=>
    cmd_rdata_q == ($past(cmd_wdata, 2) & oos_pkg::OVL_USED))
    else $error("mask read back wrong");
// acquisition equal one and three cycles back, so either latency reads alike
run_cond_a: assert property (cmd_rvalid_q && $past(cmd_sel) == 2'h0 &&
    $past(acq_state) == $past(acq_state, 3) |->
    cmd_rdata_q[3] == ($past(acq_state) != oos_pkg::OOS_ACQ_STOP))
    else $error("run bit wrong");
high_z_fall_a: assert property (
    (force_high_z_q & ~$past(low_z_sel)) == 5'h00)
    else $error("high z without low z");
high_z_rise_a: assert property ((ovl_pin[0] && low_z_sel[0]) [*4] |->
    ##[0:2] force_high_z_q[0]) else $error("high z not commanded");
stb_off_a: assert property (
    $past(operation_enable_mask) == 16'h0000 |-> !stb_oper_summary_q)
    else $error("summary without enable");
mask_c: cover property (cmd_wr && cmd_sel == 2'h2);
high_z_c: cover property (force_high_z_q != 5'h00);
stb_c: cover property (stb_oper_summary_q);
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the operation / overload status bank
// drives every bank port itself; no partner model
`timescale 1ns/100ps
`default_nettype none
module testbench;
logic ref_clk = 1'b0, sys_rst = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0;
logic cmd_clr = 1'b0;
logic hardware_event_summary = 1'b0, trigger_armed_latch = 1'b0;
logic [1:0] cmd_sel = 2'h0;
logic [15:0] cmd_wdata = 16'h0000, operation_enable_mask = 16'h0000;
logic [15:0] cmd_rdata_q;
logic [4:0] ovl_pin = 5'h00, fault_pin = 5'h00, low_z_sel = 5'h00;
logic [4:0] force_high_z_q;
logic cmd_rvalid_q, stb_oper_summary_q;
oos_pkg::oos_acq_e acq_state = oos_pkg::OOS_ACQ_STOP;
int errors = 0, samples_checked = 0;
oos_status_bank DUT (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd),
    .cmd_clr(cmd_clr),
    .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata),
    .operation_enable_mask(operation_enable_mask),
    .cmd_rdata_q(cmd_rdata_q),
    .cmd_rvalid_q(cmd_rvalid_q),
    .hardware_event_summary(hardware_event_summary),
    .trigger_armed_latch(trigger_armed_latch),
    .acq_state(acq_state),
    .ovl_pin(ovl_pin),
    .fault_pin(fault_pin),
    .low_z_sel(low_z_sel),
    .force_high_z_q(force_high_z_q),
    .stb_oper_summary_q(stb_oper_summary_q)
);
initial forever #5 ref_clk = ~ref_clk;
// ------------------------------------------------------------
// command port helpers
// ------------------------------------------------------------
task automatic chk(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
        errors++;
        $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
endtask
// only the raised strobe is lowered, so back-to-back calls of different
// kinds never assign one signal twice in a time step
task automatic strobe(input int k, input logic [1:0] s, input logic [15:0] d);
    cmd_sel <= s;
    cmd_wdata <= d;
    case (k)
        0: cmd_rd <= 1'b1;
        1: cmd_wr <= 1'b1;
        default: cmd_clr <= 1'b1;
    endcase
    @(posedge ref_clk);
    case (k)
        0: cmd_rd <= 1'b0;
        1: cmd_wr <= 1'b0;
        default: cmd_clr <= 1'b0;
    endcase
endtask
task automatic rd(input string nm, input logic [1:0] s, input logic [15:0] e);
    strobe(0, s, 16'h0000);
    @(posedge ref_clk);
    chk(nm, cmd_rdata_q, e);
    chk("read valid", 16'(cmd_rvalid_q), 16'h0001);
endtask
task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
endtask
// ------------------------------------------------------------
// scenarios
// ------------------------------------------------------------
task automatic t_mask;
    for (int s = 0; s < 4; s++) rd("reset", 2'(s), 16'h0000);
    strobe(1, 2'h2, 16'hFFFF);
    rd("mask all", 2'h2, oos_pkg::OVL_USED);
    strobe(1, 2'h2, 16'h0155);
    rd("mask pattern", 2'h2, 16'h0155);
    strobe(1, 2'h0, 16'hFFFF);
    rd("cond write", 2'h0, 16'h0000);
endtask
task automatic t_acq(input oos_pkg::oos_acq_e m);
    acq_state <= m;
    idle(3);
    rd("run cond", 2'h0, 16'h0008);
    acq_state <= oos_pkg::OOS_ACQ_STOP;
    idle(3);
    rd("stop cond", 2'h0, 16'h0000);
    rd("run event", 2'h1, 16'h0008);
    strobe(2, 2'h1, 16'h0000);
    rd("event clear", 2'h1, 16'h0000);
endtask
task automatic t_hw;
    hardware_event_summary <= 1'b1;
    trigger_armed_latch <= 1'b1;
    idle(3);
    rd("hw armed cond", 2'h0, 16'h1020);
    hardware_event_summary <= 1'b0;
    trigger_armed_latch <= 1'b0;
    idle(3);
    rd("hw armed event", 2'h1, 16'h1020);
    rd("hw armed gone", 2'h0, 16'h0000);
    strobe(2, 2'h1, 16'h0000);
endtask
task automatic t_ovl;
    strobe(1, 2'h2, oos_pkg::OVL_USED);
    for (int k = 0; k < 10; k++) begin
        low_z_sel <= k < 5 ? 5'(1 << k) : 5'h00;
        ovl_pin <= k < 5 ? 5'(1 << k) : 5'h00;
        fault_pin <= k < 5 ? 5'h00 : 5'(1 << (k - 5));
        idle(5);
        ovl_pin <= 5'h00;
        fault_pin <= 5'h00;
        idle(3);
        rd("source bit", 2'h3,
            16'(1 << (k < 5 ? k : k + 1)));
        rd("overload summary", 2'h0, 16'h0800);
        rd("overload event", 2'h1, 16'h0800);
        chk("high z", 16'(force_high_z_q), 16'(low_z_sel));
        low_z_sel <= 5'h00;
        strobe(2, 2'h3, 16'h0000);
        rd("overload cleared", 2'h0, 16'h0000);
    end
    operation_enable_mask <= 16'h0800;
    idle(2);
    chk("summary on", 16'(stb_oper_summary_q), 16'h0001);
    operation_enable_mask <= 16'h0000;
    strobe(1, 2'h2, 16'h0000);
    ovl_pin <= 5'h01;
    idle(5);
    rd("masked source", 2'h3, 16'h0001);
    rd("masked summary", 2'h0, 16'h0000);
    strobe(1, 2'h2, 16'h0001);
    rd("unmasked summary", 2'h0, 16'h0800);
endtask
task automatic conclude;
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
initial begin
    idle(4);
    sys_rst <= 1'b0;
    t_mask;
    t_acq(oos_pkg::OOS_ACQ_RUN);
    t_acq(oos_pkg::OOS_ACQ_SINGLE);
    t_hw;
    t_ovl;
    conclude;
end
endmodule
bind oos_status_bank oos_status_bank_asserts chk_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd),
    .cmd_clr(cmd_clr),
    .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata),
    .operation_enable_mask(operation_enable_mask),
    .cmd_rdata_q(cmd_rdata_q),
    .cmd_rvalid_q(cmd_rvalid_q),
    .hardware_event_summary(hardware_event_summary),
    .trigger_armed_latch(trigger_armed_latch),
    .acq_state(acq_state),
    .ovl_pin(ovl_pin),
    .fault_pin(fault_pin),
    .low_z_sel(low_z_sel),
    .force_high_z_q(force_high_z_q),
    .stb_oper_summary_q(stb_oper_summary_q)
);
`default_nettype wire
